/* design/transfer_error_irq_status.sv */
`timescale 1ns/1ps
module transfer_error_irq_status (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire event_status_pkg::unit_event_t  unit1_evt,
  input  wire event_status_pkg::unit_event_t  unit2_evt,
  input  wire event_status_pkg::event_source_t evt_src
);

  // ****************************************************************
  // Bus request and decode
  // ****************************************************************
  event_status_pkg::apb_req_t req;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] prdata_nxt;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] offs);
    hit = (a[11:2] == offs[11:2]);
  endfunction : hit

  wire sel_unit_stat  = hit(req.paddr, event_status_pkg::UNIT_STATUS_OFFS);
  wire sel_unit_clr   = hit(req.paddr, event_status_pkg::UNIT_CLEAR_OFFS);
  wire sel_event_stat = hit(req.paddr, event_status_pkg::EVENT_STATUS_OFFS);
  wire sel_event_clr  = hit(req.paddr, event_status_pkg::EVENT_CLEAR_OFFS);
  wire sel_any        = sel_unit_stat | sel_unit_clr | sel_event_stat | sel_event_clr;

  wire setup_phase    = req.psel & ~req.penable;
  // Answer comes in the first access cycle, so every transfer has no wait
  wire access_done    = req.psel & req.penable & pready_r;
  wire write_done     = access_done & req.pwrite;

  // ****************************************************************
  // Set sources
  // ****************************************************************
  logic [16:0] src_q_r;
  logic [16:0] src_level;
  logic [16:0] event_set;
  logic [15:0] unit_set;
  logic [15:0] unit_clear;
  logic [16:0] event_clear;
  logic [15:0] unit_stat;
  logic [16:0] event_stat;

  assign unit_set[event_status_pkg::UNIT1_BASE +: 8] = unit1_evt;
  assign unit_set[event_status_pkg::UNIT2_BASE +: 8] = unit2_evt;

  // Source flags are levels that stay high until software clears them at
  // their own registers; only their rising edge sets status, so clearing
  // status alone cannot re-arm detection while a source is still high.
  assign src_level = {evt_src.dev_reset, 4'h0,
                      evt_src.port_err & event_status_pkg::PORTS_PRESENT,
                      5'h00, evt_src.logical_err,
                      evt_src.port_write_in,
                      evt_src.multicast};
  // Software clears status and then the source flag (clear ordering)
  assign event_set = src_level & ~src_q_r & event_status_pkg::EVENT_VALID_MASK;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_q_r <= '0;
    end
    else
    begin
      src_q_r <= src_level;
    end
  end

  // ****************************************************************
  // Clears
  // ****************************************************************
  // Reserved and zero bits of the write data clear nothing
  assign unit_clear  = (write_done & sel_unit_clr) ? req.pwdata[15:0] : 16'h0000;
  assign event_clear = (write_done & sel_event_clr) ?
                       (req.pwdata[16:0] & event_status_pkg::EVENT_VALID_MASK) : '0;

  sticky_flags #(
    .WIDTH (event_status_pkg::UNIT_BITS)
  ) u_unit_flags (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .set_in   (unit_set),
    .clear_in (unit_clear),
    .flags    (unit_stat)
  );

  sticky_flags #(
    .WIDTH (event_status_pkg::EVENT_BITS)
  ) u_event_flags (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .set_in   (event_set),
    .clear_in (event_clear),
    .flags    (event_stat)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Status registers are read-only; writes to them are accepted and dropped.
  // Clear registers read zero.
  assign prdata_nxt = !setup_phase ? prdata_r :
                      sel_unit_stat  ? {16'h0000, unit_stat} :
                      sel_event_stat ? {15'h0000, event_stat} :
                      32'h0000_0000;
  assign pready_nxt  = setup_phase;
  assign pslverr_nxt = setup_phase ? ~sel_any : 1'b0;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r  <= event_status_pkg::STATUS_RESET;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_clear_event(int b);
    write_done && sel_event_clr && req.pwdata[b] && !event_set[b];
  endsequence

  // Taken from the pins so that a level-sensitive set would still be caught
  sequence s_source_held(int k);
    evt_src[k] [*2];
  endsequence

  sequence s_clear_write(int b);
    write_done && sel_event_clr && req.pwdata[b];
  endsequence

  sequence s_unit_clear(int b);
    write_done && sel_unit_clr && req.pwdata[b] && !unit_set[b];
  endsequence

  sequence s_setup_read;
    setup_phase && !req.pwrite;
  endsequence

  chk_unit1_done: assert property (unit1_evt.done |=> unit_stat[0])
    else $error("unit one completion did not set bit 0");
  chk_unit2_done: assert property (unit2_evt.done |=> unit_stat[8])
    else $error("unit two completion did not set bit 8");
  chk_timeout_bits: assert property (unit1_evt.timeout && unit2_evt.timeout
                                     |=> unit_stat[1] && unit_stat[9])
    else $error("timeout did not set bits 1 and 9");
  chk_xoff_bits: assert property (unit2_evt.xoff && !unit_clear[10]
                                  |=> unit_stat[10] ##1 unit_stat[10] || $past(unit_clear[10]))
    else $error("flow-control stop did not set bit 10");
  chk_err_resp: assert property (unit1_evt.err_resp |=> unit_stat[3])
    else $error("error response did not set bit 3");
  chk_unsupported: assert property (unit2_evt.unsupported |=> unit_stat[12])
    else $error("unsupported type did not set bit 12");
  chk_unit1_faults: assert property (unit1_evt[7:5] != 3'h0
                                     |=> (unit_stat[7:5] & $past(unit1_evt[7:5]))
                                         == $past(unit1_evt[7:5]))
    else $error("unit one fault did not set bits 7 to 5");
  chk_reset_event: assert property ($rose(evt_src.dev_reset) |=> event_stat[16])
    else $error("device reset request did not set bit 16");
  chk_port_error: assert property ($rose(evt_src.port_err[1]) |=> event_stat[9])
    else $error("port 1 error did not set bit 9");
  chk_logical_err: assert property ($rose(evt_src.logical_err) |=> event_stat[2])
    else $error("logical error capture did not set bit 2");
  chk_pwi_mcast: assert property ($rose(evt_src.port_write_in)
                                  && $rose(evt_src.multicast)
                                  |=> event_stat[1] && event_stat[0])
    else $error("port-write or multicast did not set status");
  chk_reserved_zero: assert property (event_stat == (event_stat
                                      & event_status_pkg::EVENT_VALID_MASK)
                                      && (!pready || !sel_event_stat || prdata[31:17] == '0))
    else $error("reserved special-event bits not zero");
  chk_clear_works: assert property (s_clear_event(0) |=> !event_stat[0])
    else $error("clear write did not clear bit 0");
  chk_clear_reads_zero: assert property (pready && sel_event_clr && !pwrite |-> prdata == '0)
    else $error("clear register did not read zero");
  chk_no_rearm: assert property (evt_src[3] ##1 s_clear_write(8) ##0 s_source_held(3)
                                 |=> !event_stat[8])
    else $error("held port error re-set its status after clear");
  chk_set_wins: assert property (event_set[16] && event_clear[16] |=> event_stat[16])
    else $error("set lost against clear in the same cycle");
  chk_zero_write: assert property (write_done && sel_unit_clr && !req.pwdata[4]
                                   && unit_stat[4] |=> unit_stat[4])
    else $error("zero write cleared a status bit");
  chk_bus_answer: assert property (setup_phase |=> pready ##1 !pready || setup_phase)
    else $error("access phase was not answered in one cycle");

  // ****************************************************************
  // Transfer-unit bit map
  // ****************************************************************
  chk_unit1_timeout: assert property (unit1_evt.timeout |=> unit_stat[1])
    else $error("unit one timeout did not set bit 1");
  chk_unit2_timeout: assert property (unit2_evt.timeout |=> unit_stat[9])
    else $error("unit two timeout did not set bit 9");
  chk_unit1_xoff: assert property (unit1_evt.xoff |=> unit_stat[2])
    else $error("unit one flow-control stop did not set bit 2");
  chk_unit2_err_resp: assert property (unit2_evt.err_resp |=> unit_stat[11])
    else $error("unit two error response did not set bit 11");
  chk_unit1_unsupported: assert property (unit1_evt.unsupported |=> unit_stat[4])
    else $error("unit one unsupported type did not set bit 4");
  chk_unit1_dma: assert property (unit1_evt.dma_err |=> unit_stat[5])
    else $error("unit one DMA error did not set bit 5");
  chk_unit1_retry: assert property (unit1_evt.retry |=> unit_stat[6])
    else $error("unit one retry did not set bit 6");
  chk_unit1_credit: assert property (unit1_evt.no_credit |=> unit_stat[7])
    else $error("unit one credit stall did not set bit 7");
  chk_unit2_upper: assert property (unit2_evt[7:5] != 3'h0
                                    |=> (unit_stat[15:13] & $past(unit2_evt[7:5]))
                                        == $past(unit2_evt[7:5]))
    else $error("unit two fault did not set bits 15 to 13");
  chk_unit_quiet: assert property (unit1_evt == '0 && unit2_evt == '0
                                   && !(write_done && sel_unit_clr) |=> $stable(unit_stat))
    else $error("unit status changed with no event or clear");
  chk_unit_clear_bit: assert property (s_unit_clear(3) |=> !unit_stat[3])
    else $error("unit clear write did not clear bit 3");
  chk_unit_clear_high: assert property (s_unit_clear(14) |=> !unit_stat[14])
    else $error("unit clear write did not clear bit 14");
  chk_unit_set_wins: assert property (unit_set[0] && unit_clear[0] |=> unit_stat[0])
    else $error("unit event lost against clear in the same cycle");

  // ****************************************************************
  // Special-event bit map and clearing
  // ****************************************************************
  chk_port0_error: assert property ($rose(evt_src.port_err[0]) |=> event_stat[8])
    else $error("port 0 error did not set bit 8");
  chk_port2_error: assert property ($rose(evt_src.port_err[2]) |=> event_stat[10])
    else $error("port 2 error did not set bit 10");
  chk_port3_error: assert property ($rose(evt_src.port_err[3]) |=> event_stat[11])
    else $error("port 3 error did not set bit 11");
  chk_port_write: assert property ($rose(evt_src.port_write_in) |=> event_stat[1])
    else $error("port-write-in request did not set bit 1");
  chk_multicast: assert property ($rose(evt_src.multicast) |=> event_stat[0])
    else $error("multicast event did not set bit 0");
  chk_event_quiet: assert property (evt_src == '0 && !(write_done && sel_event_clr)
                                    |=> $stable(event_stat))
    else $error("special status changed with no edge or clear");
  chk_clear_reset: assert property (s_clear_event(16) |=> !event_stat[16])
    else $error("clear write did not clear bit 16");
  chk_clear_port3: assert property (s_clear_event(11) |=> !event_stat[11])
    else $error("clear write did not clear bit 11");
  chk_clear_port2: assert property (s_clear_event(10) |=> !event_stat[10])
    else $error("clear write did not clear bit 10");
  chk_clear_port1: assert property (s_clear_event(9) |=> !event_stat[9])
    else $error("clear write did not clear bit 9");
  chk_clear_port0: assert property (s_clear_event(8) |=> !event_stat[8])
    else $error("clear write did not clear bit 8");
  chk_clear_logical: assert property (s_clear_event(2) |=> !event_stat[2])
    else $error("clear write did not clear bit 2");
  chk_clear_pwi: assert property (s_clear_event(1) |=> !event_stat[1])
    else $error("clear write did not clear bit 1");
  chk_clear_zero_bit: assert property (write_done && sel_event_clr && !req.pwdata[8]
                                       && event_stat[8] |=> event_stat[8])
    else $error("zero bit of a clear write cleared bit 8");
  chk_status_ro: assert property (write_done && sel_event_stat && event_set == '0
                                  |=> $stable(event_stat))
    else $error("write to the special status changed it");
  chk_held_reset: assert property (evt_src[7] ##1 s_clear_write(16) ##0 s_source_held(7)
                                   |=> !event_stat[16])
    else $error("held reset request re-set its status after clear");
  chk_held_mcast: assert property (evt_src[0] ##1 s_clear_write(0) ##0 s_source_held(0)
                                   |=> !event_stat[0])
    else $error("held multicast source re-set its status after clear");
  chk_held_pwi: assert property (evt_src[1] ##1 s_clear_write(1) ##0 s_source_held(1)
                                 |=> !event_stat[1])
    else $error("held port-write source re-set its status after clear");
  chk_held_logical: assert property (evt_src[2] ##1 s_clear_write(2) ##0 s_source_held(2)
                                     |=> !event_stat[2])
    else $error("held logical error re-set its status after clear");
  chk_held_port3: assert property (evt_src[6] ##1 s_clear_write(11) ##0 s_source_held(6)
                                   |=> !event_stat[11])
    else $error("held port 3 error re-set its status after clear");

  // ****************************************************************
  // Register bus
  // ****************************************************************
  chk_unmapped_error: assert property (setup_phase && !sel_any
                                       |=> pready && pslverr && prdata == '0)
    else $error("unmapped access was not refused with zero data");
  chk_mapped_no_error: assert property (setup_phase && sel_any |=> pready && !pslverr)
    else $error("mapped access reported an error");
  chk_error_with_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  chk_unit_read: assert property (s_setup_read ##0 sel_unit_stat
                                  |=> prdata == {16'h0000, $past(unit_stat)})
    else $error("unit status read returned wrong data");
  chk_event_read: assert property (s_setup_read ##0 sel_event_stat
                                   |=> prdata == {15'h0000, $past(event_stat)})
    else $error("special status read returned wrong data");
  chk_unit_clear_reads: assert property (pready && sel_unit_clr && !pwrite |-> prdata == '0)
    else $error("unit clear register did not read zero");
  chk_read_hold: assert property (!setup_phase |=> $stable(prdata))
    else $error("read data moved outside a setup cycle");

endmodule : transfer_error_irq_status

/* design/event_status_pkg.sv */
package event_status_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] UNIT_STATUS_OFFS  = 12'h260;
  localparam logic [11:0] UNIT_CLEAR_OFFS   = 12'h268;
  localparam logic [11:0] EVENT_STATUS_OFFS = 12'h270;
  localparam logic [11:0] EVENT_CLEAR_OFFS  = 12'h278;

  localparam logic [31:0] STATUS_RESET      = 32'h0000_0000;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          UNIT_BITS         = 16;
  localparam int          EVENT_BITS        = 17;
  localparam int          UNIT1_BASE        = 0;
  localparam int          UNIT2_BASE        = 8;
  localparam int          EVT_MULTICAST     = 0;
  localparam int          EVT_PORT_WRITE    = 1;
  localparam int          EVT_LOGICAL_ERR   = 2;
  localparam int          EVT_PORT_ERR_BASE = 8;
  localparam int          EVT_DEV_RESET     = 16;
  // Valid bits of the special-event register: 16, 11..8, 2..0
  localparam logic [16:0] EVENT_VALID_MASK  = 17'h1_0F07;
  // Ports present; 4'h3 would describe a two-port variant
  localparam logic [3:0]  PORTS_PRESENT     = 4'hF;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Packed so that bit 0 is completion and bit 7 is credit stall
  typedef struct packed {
    logic no_credit;
    logic retry;
    logic dma_err;
    logic unsupported;
    logic err_resp;
    logic xoff;
    logic timeout;
    logic done;
  } unit_event_t;

  // Level source flags held by the port and logical-layer logic
  typedef struct packed {
    logic       dev_reset;
    logic [3:0] port_err;
    logic       logical_err;
    logic       port_write_in;
    logic       multicast;
  } event_source_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : event_status_pkg

/* design/sticky_flags.sv */
`timescale 1ns/1ps
module sticky_flags #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // ****************************************************************
  // Set beats clear so an event in the clearing cycle is kept
  // ****************************************************************
  assign flags_nxt = set_in | (flags_r & ~clear_in);
  assign flags     = flags_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

endmodule : sticky_flags

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  // ************************************************************
  // Signals and counters
  // ************************************************************
  logic                            clk_sys;
  logic                            rst_n;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [11:0]                     paddr;
  logic [31:0]                     pwdata;
  logic [31:0]                     prdata;
  logic                            pready;
  logic                            pslverr;
  event_status_pkg::unit_event_t   unit1_evt;
  event_status_pkg::unit_event_t   unit2_evt;
  event_status_pkg::event_source_t evt_src;
  int                              n_fail;
  int                              check_count;
  int                              i;
  logic [31:0]                     rd;
  logic                            err;
  logic [15:0]                     exp_u;
  logic [7:0]                      ev1;
  logic [7:0]                      ev2;
  logic [7:0]                      evc;
  logic [15:0]                     clr;

  transfer_error_irq_status dut (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .unit1_evt (unit1_evt),
    .unit2_evt (unit2_evt),
    .evt_src   (evt_src)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Expectations, checks and bus cycles
  // ************************************************************
  // Source index follows the packing of event_source_t
  function automatic logic [31:0] ev_bit(input int k);
    if (k < 3)
      return 32'h0000_0001 << (event_status_pkg::EVT_MULTICAST + k);
    if (k < 7)
      return 32'h0000_0001 << (event_status_pkg::EVT_PORT_ERR_BASE + k - 3);
    return 32'h0000_0001 << event_status_pkg::EVT_DEV_RESET;
  endfunction : ev_bit

  // An event landing on the clearing edge survives the clear
  function automatic logic [15:0] unit_next(input logic [15:0] s, input logic [15:0] set,
                                            input logic [15:0] c, input logic [7:0] late);
    return ((s | set) & ~c) | {8'h00, late};
  endfunction : unit_next

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Request held until pready is sampled high; ev pulses unit one on that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [7:0] ev);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable   <= 1'b1;
    unit1_evt <= ev;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      chk("pready", 32'h0000_0001, 32'h0000_0000);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel      <= 1'b0;
    penable   <= 1'b0;
    unit1_evt <= 8'h00;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000, 8'h00);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys);
    unit1_evt <= a;
    unit2_evt <= b;
    @(posedge clk_sys);
    unit1_evt <= 8'h00;
    unit2_evt <= 8'h00;
  endtask : pulse

  task automatic src_step(input int k, input logic v);
    @(posedge clk_sys);
    evt_src[k] <= v;
    repeat (3) @(posedge clk_sys);
  endtask : src_step

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    unit1_evt = 8'h00;
    unit2_evt = 8'h00;
    evt_src = 8'h00;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    void'($urandom(32'h29b4_83e4));
    rdchk(12'h260, 32'h0000_0000, "unit_status_rst");
    rdchk(12'h268, 32'h0000_0000, "unit_clear_read");
    rdchk(12'h270, 32'h0000_0000, "event_status_rst");
    rdchk(12'h278, 32'h0000_0000, "event_clear_rst");
    apb(1'b0, 12'h27C, 32'h0000_0000, 8'h00);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    chk("unmapped_data", 32'h0000_0000, rd);
    // Every transfer-unit condition, one at a time
    for (i = 0; i < 16; i++)
    begin
      pulse(i < 8 ? 8'h01 << i : 8'h00, i < 8 ? 8'h00 : 8'h01 << (i - 8));
      rdchk(12'h260, 32'h0000_0001 << i, "unit_set");
      apb(1'b1, 12'h268, 32'h0000_0001 << i, 8'h00);
      rdchk(12'h260, 32'h0000_0000, "unit_clear");
    end
    // A clear with the source still high must not re-arm the bit
    for (i = 0; i < 8; i++)
    begin
      src_step(i, 1'b1);
      rdchk(12'h270, ev_bit(i), "event_set");
      apb(1'b1, 12'h278, ev_bit(i), 8'h00);
      repeat (3) @(posedge clk_sys);
      rdchk(12'h270, 32'h0000_0000, "event_held_src");
      src_step(i, 1'b0);
      src_step(i, 1'b1);
      rdchk(12'h270, ev_bit(i), "event_rearm");
      src_step(i, 1'b0);
      apb(1'b1, 12'h278, ev_bit(i), 8'h00);
    end
    // A source edge in the clearing cycle keeps its status bit
    fork
      apb(1'b1, 12'h278, 32'h0001_0000, 8'h00);
      begin
        repeat (2) @(posedge clk_sys);
        evt_src[7] <= 1'b1;
      end
    join
    rdchk(12'h270, 32'h0001_0000, "event_set_wins");
    src_step(7, 1'b0);
    // Reserved, zero and status-register writes leave the bits alone
    @(posedge clk_sys);
    evt_src <= 8'hFF;
    repeat (3) @(posedge clk_sys);
    apb(1'b1, 12'h278, ~32'h0001_0F07, 8'h00);
    apb(1'b1, 12'h270, 32'hFFFF_FFFF, 8'h00);
    chk("status_write_err", 32'h0000_0000, {31'h0, err});
    rdchk(12'h270, 32'h0001_0F07, "event_all");
    apb(1'b1, 12'h278, 32'hFFFF_FFFF, 8'h00);
    rdchk(12'h270, 32'h0000_0000, "event_clear_all");
    evt_src <= 8'h00;
    // Random unit traffic; clears collide with fresh events
    exp_u = 16'h0000;
    apb(1'b1, 12'h268, 32'h0000_0001, 8'h01);
    exp_u = unit_next(exp_u, 16'h0000, 16'h0001, 8'h01);
    rdchk(12'h260, {16'h0000, exp_u}, "unit_set_wins");
    repeat (40)
    begin
      ev1 = 8'($urandom);
      ev2 = 8'($urandom);
      evc = 8'($urandom);
      clr = 16'($urandom);
      pulse(ev1, ev2);
      apb(1'b1, 12'h268, {16'h0000, clr}, evc);
      exp_u = unit_next(exp_u, {ev2, ev1}, clr, evc);
      rdchk(12'h260, {16'h0000, exp_u}, "unit_random");
    end
    tally_and_finish();
  end
endmodule : tb
